//--- shared/smi_pkg.sv
package smi_pkg;

	////////////////////////////////////////////////////////////////////////
	localparam int unsigned CLK_HZ = 20_000_000;
	localparam int unsigned SEL_TIME_MS = 500;
	// Low time is a least time, counted in whole cycles with no rounding up, and at least 1
	localparam int unsigned SEL_CYCLES =
		(SEL_TIME_MS * (CLK_HZ / 1000) + 0) > 0 ?
		SEL_TIME_MS * (CLK_HZ / 1000) : 1;
	localparam int unsigned SEL_CNT_W = 24;

	localparam logic [6:0] SLAVE_ADDR = 7'h5c;
	localparam int unsigned BITS_PER_BYTE = 8;
	localparam int unsigned FRAME_BYTES = 6;
	localparam logic [3:0] BIT_ACK = 4'h8;
	localparam logic [2:0] LAST_BYTE = 3'h5;
	localparam logic [15:0] CRC_INIT = 16'hffff;
	localparam logic [15:0] CRC_POLY = 16'ha001;

	////////////////////////////////////////////////////////////////////////
	typedef struct packed {
		logic [15:0] humidity;
		logic [15:0] temperature;
	} smi_reading_s;

	// Byte order on the wire: humidity, temperature, then CRC low first
	typedef struct packed {
		smi_reading_s reading;
		logic [15:0] crc;
	} smi_frame_s;

	typedef enum logic {
		SMI_MODE_SINGLE,
		SMI_MODE_I2C
	} smi_mode_e;

	// Reflected CRC-16 over the four reading bytes
	function automatic logic [15:0] smi_crc(input smi_reading_s r);
		logic [15:0] c;
		logic [31:0] d;
		c = CRC_INIT;
		d = r;
		for (int i = 3; i >= 0; i--) begin
			c = c ^ {8'h00, d[i*8 +: 8]};
			for (int b = 0; b < 8; b++) begin
				c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
			end
		end
		return c;
	endfunction

	function automatic smi_frame_s smi_make_frame(input smi_reading_s r);
		smi_frame_s f;
		logic [15:0] c;
		c = smi_crc(r);
		f.reading = r;
		f.crc = {c[7:0], c[15:8]};
		return f;
	endfunction

endpackage

//--- core/smi_sync.sv
`timescale 1ns/1ps
module smi_sync #(
	parameter int unsigned W = 2
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [W-1:0] asyncIn,
	output logic [W-1:0] syncOut
);

	logic [W-1:0] stage1_reg;

	// Pins idle high under their pull-ups
	genvar g;
	generate
		for (g = 0; g < W; g++) begin : gSync
			always_ff @(posedge ref_clk) begin
				if (rst) begin
					stage1_reg[g] <= 1'b1;
					syncOut[g] <= 1'b1;
				end else begin
					stage1_reg[g] <= asyncIn[g];
					syncOut[g] <= stage1_reg[g];
				end
			end
		end
	endgenerate

endmodule

//--- core/smi_top.sv
`timescale 1ns/1ps
module smi_top #(
	parameter int unsigned SEL_CYCLES = smi_pkg::SEL_CYCLES
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic sclIn,
	input wire logic sdaIn,
	output logic sdaOut,
	output logic sdaOe,
	input wire smi_pkg::smi_reading_s reading,
	output smi_pkg::smi_frame_s frameOut,
	output logic modeDone,
	output smi_pkg::smi_mode_e mode,
	output logic [7:0] wrData,
	output logic wrStrobe
);

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_ACK_ADDR,
		ST_WRITE,
		ST_ACK_WR,
		ST_READ,
		ST_ACK_RD
	} smi_state_e;

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers
	logic [1:0] pinSync;
	logic sclS;
	logic sdaS;
	logic sclPrev_reg;
	logic sdaPrev_reg;

	smi_sync #(.W(2)) uSync (
		.ref_clk(ref_clk),
		.rst(rst),
		.asyncIn({sclIn, sdaIn}),
		.syncOut(pinSync)
	);

	assign sclS = pinSync[1];
	assign sdaS = pinSync[0];

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			sclPrev_reg <= 1'b1;
			sdaPrev_reg <= 1'b1;
		end else begin
			sclPrev_reg <= sclS;
			sdaPrev_reg <= sdaS;
		end
	end

	logic sclRise;
	logic sclFall;
	logic startCond;
	logic stopCond;

	assign sclRise = sclS & ~sclPrev_reg;
	assign sclFall = ~sclS & sclPrev_reg;
	assign startCond = sclS & sclPrev_reg & sdaPrev_reg & ~sdaS;
	assign stopCond = sclS & sclPrev_reg & ~sdaPrev_reg & sdaS;

	////////////////////////////////////////////////////////////////////////
	// Mode selection, made once per reset
	logic [smi_pkg::SEL_CNT_W-1:0] selCnt_reg;
	logic isI2c;
	// The synchroniser shows its reset level for two edges after
	// release, so the pin is not judged until a real sample arrives
	logic [1:0] pinValid_reg;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			pinValid_reg <= 2'h0;
		end else begin
			pinValid_reg <= {pinValid_reg[0], 1'b1};
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			selCnt_reg <= '0;
			modeDone <= 1'b0;
			mode <= smi_pkg::SMI_MODE_SINGLE;
		end else if (!modeDone && pinValid_reg[1]) begin
			if (sclS) begin
				mode <= smi_pkg::SMI_MODE_I2C;
				modeDone <= 1'b1;
			end else if (selCnt_reg ==
				smi_pkg::SEL_CNT_W'(SEL_CYCLES - 1)) begin
				mode <= smi_pkg::SMI_MODE_SINGLE;
				modeDone <= 1'b1;
			end else begin
				selCnt_reg <= selCnt_reg + 1'b1;
			end
		end
		// No path clears modeDone short of reset, so the choice holds
	end

	assign isI2c = modeDone && (mode == smi_pkg::SMI_MODE_I2C);

	////////////////////////////////////////////////////////////////////////
	// Readout frame, refreshed every cycle in either mode
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			frameOut <= '0;
		end else begin
			frameOut <= smi_pkg::smi_make_frame(reading);
		end
	end

	function automatic logic [7:0] frame_byte(
		input smi_pkg::smi_frame_s f,
		input logic [2:0] idx
	);
		logic [47:0] flat;
		flat = f;
		unique case (idx)
			3'h0: frame_byte = flat[47:40];
			3'h1: frame_byte = flat[39:32];
			3'h2: frame_byte = flat[31:24];
			3'h3: frame_byte = flat[23:16];
			3'h4: frame_byte = flat[15:8];
			3'h5: frame_byte = flat[7:0];
			default: frame_byte = 8'hff;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////
	// I2C slave
	smi_state_e state_reg;
	logic [3:0] bitCnt_reg;
	logic [7:0] rxShift_reg;
	logic [7:0] txShift_reg;
	logic readDir_reg;
	logic [2:0] bytePtr_reg;
	smi_pkg::smi_frame_s snap_reg;
	logic [7:0] nextByte;

	assign nextByte = frame_byte(snap_reg, bytePtr_reg);

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state_reg <= ST_IDLE;
			bitCnt_reg <= 4'h0;
			rxShift_reg <= 8'h00;
			txShift_reg <= 8'h00;
			readDir_reg <= 1'b0;
			bytePtr_reg <= 3'h0;
			snap_reg <= '0;
			sdaOe <= 1'b0;
			wrData <= 8'h00;
			wrStrobe <= 1'b0;
		end else begin
			wrStrobe <= 1'b0;
			if (!isI2c || stopCond) begin
				state_reg <= ST_IDLE;
				sdaOe <= 1'b0;
			end else if (startCond) begin
				// Repeated start also lands here
				state_reg <= ST_ADDR;
				bitCnt_reg <= 4'h0;
				sdaOe <= 1'b0;
			end else begin
				unique case (state_reg)
				ST_IDLE: begin
					sdaOe <= 1'b0;
				end
				ST_ADDR, ST_WRITE: begin
					if (sclRise && bitCnt_reg != smi_pkg::BIT_ACK) begin
						rxShift_reg <= {rxShift_reg[6:0], sdaS};
						bitCnt_reg <= bitCnt_reg + 1'b1;
					end else if (sclFall &&
						bitCnt_reg == smi_pkg::BIT_ACK) begin
						if (state_reg == ST_WRITE) begin
							sdaOe <= 1'b1;
							wrData <= rxShift_reg;
							wrStrobe <= 1'b1;
							state_reg <= ST_ACK_WR;
						end else if (rxShift_reg[7:1] ==
							smi_pkg::SLAVE_ADDR) begin
							// Only one such sensor per segment
							sdaOe <= 1'b1;
							readDir_reg <= rxShift_reg[0];
							bytePtr_reg <= 3'h0;
							snap_reg <= frameOut;
							state_reg <= ST_ACK_ADDR;
						end else begin
							state_reg <= ST_IDLE;
						end
					end
				end
				ST_ACK_ADDR, ST_ACK_WR: begin
					if (sclFall) begin
						bitCnt_reg <= 4'h0;
						if (state_reg == ST_ACK_ADDR && readDir_reg) begin
							sdaOe <= ~nextByte[7];
							txShift_reg <= {nextByte[6:0], 1'b1};
							bitCnt_reg <= 4'h1;
							state_reg <= ST_READ;
						end else begin
							sdaOe <= 1'b0;
							state_reg <= ST_WRITE;
						end
					end
				end
				ST_READ: begin
					if (sclFall) begin
						if (bitCnt_reg == smi_pkg::BIT_ACK) begin
							sdaOe <= 1'b0;
							state_reg <= ST_ACK_RD;
						end else begin
							sdaOe <= ~txShift_reg[7];
							txShift_reg <= {txShift_reg[6:0], 1'b1};
							bitCnt_reg <= bitCnt_reg + 1'b1;
						end
					end
				end
				ST_ACK_RD: begin
					if (sclRise) begin
						if (sdaS) begin
							// Host declined more bytes
							state_reg <= ST_IDLE;
						end else if (bytePtr_reg != smi_pkg::LAST_BYTE) begin
							bytePtr_reg <= bytePtr_reg + 1'b1;
						end
					end else if (sclFall) begin
						sdaOe <= ~nextByte[7];
						txShift_reg <= {nextByte[6:0], 1'b1};
						bitCnt_reg <= 4'h1;
						state_reg <= ST_READ;
					end
				end
				endcase
			end
		end
	end

	// Open drain: only ever pulls low, the pull-up makes the high
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			sdaOut <= 1'b0;
		end else begin
			sdaOut <= 1'b0;
		end
	end

endmodule

//--- bench/smi_props.sv
`timescale 1ns/1ps
module smi_props #(
	parameter int unsigned SEL_CYCLES = 20
) (
	input logic ref_clk,
	input logic rst,
	input logic sclIn,
	input logic sdaOe,
	input smi_pkg::smi_reading_s reading,
	input smi_pkg::smi_frame_s frameOut,
	input logic modeDone,
	input smi_pkg::smi_mode_e mode,
	input logic wrStrobe
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	// Any high sample restarts the run, so only unbroken lows count
	int unsigned lowCnt_reg;
	always_ff @(posedge ref_clk) begin
		lowCnt_reg <= (rst || sclIn) ? 0 : lowCnt_reg + 1;
	end
	chk_single_min: assert property (
		$rose(modeDone) && !mode |-> lowCnt_reg >= SEL_CYCLES)
		else $error("single picked early");
	chk_i2c_pick: assert property (
		(!modeDone && sclIn) [*3] |-> ##[1:3] (modeDone && mode))
		else $error("i2c not picked");
	chk_mode_hold: assert property (
		modeDone |=> modeDone && $stable(mode))
		else $error("mode moved");
	chk_oe_i2c: assert property (sdaOe |-> modeDone && mode)
		else $error("drive outside i2c");
	chk_oe_bit: assert property ($rose(sdaOe) |-> sdaOe [*8])
		else $error("drive too short");
	chk_frame_now: assert property (
		!$past(rst) |-> frameOut.reading == $past(reading))
		else $error("frame stale");
	chk_strobe_ack: assert property (
		wrStrobe |-> sdaOe ##1 (sdaOe && !wrStrobe))
		else $error("strobe without ack");
	cov_i2c: cover property ($rose(modeDone) && mode);
	cov_single: cover property ($rose(modeDone) && !mode);
	cov_write: cover property (wrStrobe);
endmodule

//--- bench/smi_host.sv
`timescale 1ns/1ps
module smi_host (
	input logic ref_clk,
	input logic sdaWire,
	output logic scl,
	output logic sdaPull
);
	initial begin
		scl = 1'b1;
		sdaPull = 1'b0;
	end
	task automatic half();
		repeat (5) @(negedge ref_clk);
	endtask
	task automatic bitx(input logic b, output logic r);
		sdaPull = !b;
		half();
		scl = 1'b1;
		half();
		r = sdaWire;
		scl = 1'b0;
		half();
	endtask
	// Works from idle or mid-frame, so it also serves as repeated start
	task automatic start();
		sdaPull = 1'b0;
		half();
		scl = 1'b1;
		half();
		sdaPull = 1'b1;
		half();
		scl = 1'b0;
		half();
	endtask
	// Sole sensor on the segment, so no arbitration is modelled
	task automatic xfer(input logic [7:0] d, input logic last,
		output logic [7:0] q, output logic ack);
		for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
		bitx(last, ack);
	endtask
endmodule

//--- bench/tb.sv
`timescale 1ns/1ps
module tb;
	localparam int unsigned SEL_CYCLES = 20;
	logic ref_clk = 1'b0, rst = 1'b1;
	logic sclPin, sdaPull, sdaWire, sdaOe, sdaOut, modeDone, wrStrobe;
	logic [7:0] wrData;
	smi_pkg::smi_reading_s reading = 32'h1234_abcd;
	smi_pkg::smi_frame_s frameOut;
	smi_pkg::smi_mode_e mode;
	int errors = 0, checks_done = 0;
	always #25 ref_clk = ~ref_clk;
	// Open drain wire: low when either side pulls, pull-up otherwise
	assign sdaWire = !((sdaOe && !sdaOut) || sdaPull);
	smi_top #(.SEL_CYCLES(SEL_CYCLES)) DUT (.ref_clk(ref_clk), .rst(rst),
		.sclIn(sclPin), .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOe(sdaOe),
		.reading(reading), .frameOut(frameOut), .modeDone(modeDone),
		.mode(mode), .wrData(wrData), .wrStrobe(wrStrobe));
	smi_host host (.ref_clk(ref_clk), .sdaWire(sdaWire), .scl(sclPin),
		.sdaPull(sdaPull));
	////////////////////////////////////////////////////////////////
	task automatic check(input string n, input logic [47:0] got, exp);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %s exp %h got %h", n, exp, got);
		end
	endtask
	// Bitwise form of the reflected checksum, bytes in wire order
	function automatic logic [15:0] crcRef(input logic [31:0] v);
		logic [15:0] c;
		logic fb;
		c = smi_pkg::CRC_INIT;
		for (int k = 3; k >= 0; k--) begin
			for (int b = 0; b < 8; b++) begin
				fb = c[0] ^ v[k*8 + b];
				c = c >> 1;
				if (fb) begin
					c = c ^ smi_pkg::CRC_POLY;
				end
			end
		end
		return c;
	endfunction
	task automatic summarize();
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic powerUp(input logic s);
		rst = 1'b1;
		host.scl = s;
		repeat (12) @(negedge ref_clk);
		rst = 1'b0;
	endtask
	task automatic testI2c();
		logic [2:0] a;
		logic [7:0] q;
		logic [47:0] got;
		logic [15:0] crc;
		powerUp(1'b1);
		repeat (8) @(negedge ref_clk);
		check("i2c", {modeDone, mode}, 2'b11);
		host.start();
		host.xfer({smi_pkg::SLAVE_ADDR, 1'b0}, 1'b1, q, a[2]);
		host.xfer(8'ha5, 1'b1, q, a[1]);
		host.start();
		host.xfer(8'h24, 1'b1, q, a[0]);
		check("wr", {a, wrData}, 11'h1a5);
		reading = 32'h5a3c_0f81;
		crc = crcRef(reading);
		repeat (3) @(negedge ref_clk);
		check("frame", frameOut, {reading, crc[7:0], crc[15:8]});
		host.start();
		host.xfer({smi_pkg::SLAVE_ADDR, 1'b1}, 1'b1, q, a[1]);
		for (int i = 5; i >= 0; i--) begin
			host.xfer(8'hff, i == 0, got[i*8 +: 8], a[0]);
		end
		check("rd", {a[1], got[47:16]}, 33'h05a3c0f81);
		check("crc", got[15:0], {crc[7:0], crc[15:8]});
	endtask
	// Clock pin goes high part way through the low count
	task automatic testLateHigh();
		powerUp(1'b0);
		repeat (SEL_CYCLES / 2) @(negedge ref_clk);
		check("late", modeDone, 1'b0);
		host.scl = 1'b1;
		repeat (6) @(negedge ref_clk);
		check("late", {modeDone, mode}, 2'b11);
	endtask
	task automatic testSingle();
		powerUp(1'b0);
		repeat (SEL_CYCLES) @(negedge ref_clk);
		check("early", modeDone, 1'b0);
		repeat (7) @(negedge ref_clk);
		host.scl = 1'b1;
		repeat (9) @(negedge ref_clk);
		check("single", {modeDone, mode}, 2'b10);
	endtask
	initial begin
		testI2c();
		testLateHigh();
		testSingle();
		summarize();
	end
	// Tests take about 1500 cycles; this allows over ten times that
	initial begin
		#2_000_000;
		errors++;
		summarize();
	end
endmodule
bind smi_top smi_props #(.SEL_CYCLES(SEL_CYCLES)) props (.ref_clk(ref_clk),
	.rst(rst), .sclIn(sclIn), .sdaOe(sdaOe), .reading(reading),
	.frameOut(frameOut), .modeDone(modeDone), .mode(mode),
	.wrStrobe(wrStrobe));
